// ### dps_pkg.sv
package dps_pkg;
    // token space geometry
    localparam int TOKEN_COUNT = 8;
    localparam int INDEX_W = 3;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 19;
    // pin timing at 50 MHz, 20 ns period
    localparam int CLK_PERIOD_NS = 20;
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 40;
    localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    // host command codes
    typedef enum logic [1:0] {
        DPS_CMD_CLAIM = 2'h0,
        DPS_CMD_RELEASE = 2'h1,
        DPS_CMD_POLL = 2'h2,
        DPS_CMD_INIT = 2'h3
    } dps_cmd_t;
    // controller states, one-hot
    typedef enum logic [5:0] {
        DPS_IDLE = 6'h01,
        DPS_WSET = 6'h02,
        DPS_WSTB = 6'h04,
        DPS_RSET = 6'h08,
        DPS_RSTB = 6'h10,
        DPS_DONE = 6'h20
    } dps_state_t;
endpackage : dps_pkg

// ### dps_timer.sv
`timescale 1ns/1ps
// counts down a phase length and flags its last cycle
module dps_timer (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [dps_pkg::CNT_W-1:0] load_val,
    output logic expired
);
    logic [dps_pkg::CNT_W-1:0] cnt_ff;

    // reload on each new phase, otherwise count down to zero
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt_ff <= '0;
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
        end
    end

    // last cycle of phase is when the counter sits at one
    // kept independent of load: load is decoded from expired, so gating here would loop
    assign expired = (cnt_ff == {{(dps_pkg::CNT_W-1){1'b0}}, 1'b1});
endmodule : dps_timer

// ### dps_host.sv
`timescale 1ns/1ps
// Notes on behaviour
// - zero requests token, one releases it
// - token select low, then ordinary memory strobes
// - claim writes zero first, then reads back
// - after failure poll or withdraw with one
// - write one to every token at start
// - array deselected, second enable and select low
module dps_host #(
    parameter int SETUP_CYCLES = dps_pkg::SETUP_CYC,
    parameter int STROBE_CYCLES = dps_pkg::STROBE_CYC
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_op,
    input wire logic [dps_pkg::INDEX_W-1:0] cmd_index,
    output logic rsp_valid,
    output logic rsp_granted,
    output logic [dps_pkg::DATA_W-1:0] rsp_data,
    output logic init_done,
    output logic chip_enable_n,
    output logic second_chip_enable,
    output logic token_space_select_n,
    output logic write_n,
    output logic output_enable_n,
    output logic [1:0] byte_lane_enables_n,
    output logic [dps_pkg::ADDR_W-1:0] port_addr,
    output logic [dps_pkg::DATA_W-1:0] port_data_out,
    output logic port_data_oe_n,
    input wire logic [dps_pkg::DATA_W-1:0] port_data_in
);
    dps_pkg::dps_state_t state_ff;
    dps_pkg::dps_state_t nxt_state;
    logic [1:0] op_ff;               // command in flight
    logic [dps_pkg::INDEX_W-1:0] idx_ff; // token being worked on
    logic wbit_ff;                   // value written on bit zero
    logic init_ff;                   // initial release sweep running
    logic init_done_ff;
    logic rsp_valid_ff;
    logic rsp_granted_ff;
    logic [dps_pkg::DATA_W-1:0] rsp_data_ff;
    logic phase_load;
    logic [dps_pkg::CNT_W-1:0] phase_len;
    logic phase_end;

    // decodes whether an op begins with a write cycle
    function automatic logic op_writes(input logic [1:0] op);
        op_writes = (op != dps_pkg::DPS_CMD_POLL);
    endfunction : op_writes

    // decodes whether an op ends with a read-back
    function automatic logic op_reads(input logic [1:0] op);
        op_reads = (op == dps_pkg::DPS_CMD_CLAIM) || (op == dps_pkg::DPS_CMD_POLL);
    endfunction : op_reads

    dps_timer u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(phase_load),
        .load_val(phase_len),
        .expired(phase_end)
    );

    // phase lengths: address setup, then strobe width
    always_comb begin
        phase_load = 1'b0;
        phase_len = SETUP_CYCLES[dps_pkg::CNT_W-1:0];
        if (state_ff == dps_pkg::DPS_IDLE && (init_ff || cmd_valid)) begin
            phase_load = 1'b1;
        end else if ((state_ff == dps_pkg::DPS_WSET || state_ff == dps_pkg::DPS_RSET)
                     && phase_end) begin
            phase_load = 1'b1;
            phase_len = STROBE_CYCLES[dps_pkg::CNT_W-1:0];
        end else if (state_ff == dps_pkg::DPS_WSTB && phase_end && op_reads(op_ff)) begin
            phase_load = 1'b1; // write then read, never the reverse
        end
    end

    // sequencer next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            dps_pkg::DPS_IDLE: begin
                if (init_ff) begin
                    nxt_state = dps_pkg::DPS_WSET;
                end else if (cmd_valid) begin
                    nxt_state = op_writes(cmd_op) ? dps_pkg::DPS_WSET : dps_pkg::DPS_RSET;
                end
            end
            dps_pkg::DPS_WSET: if (phase_end) nxt_state = dps_pkg::DPS_WSTB;
            dps_pkg::DPS_WSTB: begin
                if (phase_end) begin
                    nxt_state = op_reads(op_ff) ? dps_pkg::DPS_RSET : dps_pkg::DPS_DONE;
                end
            end
            dps_pkg::DPS_RSET: if (phase_end) nxt_state = dps_pkg::DPS_RSTB;
            dps_pkg::DPS_RSTB: if (phase_end) nxt_state = dps_pkg::DPS_DONE;
            dps_pkg::DPS_DONE: nxt_state = dps_pkg::DPS_IDLE;
            default: nxt_state = dps_pkg::DPS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_ff <= dps_pkg::DPS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // latch command; init sweep walks all eight tokens writing one
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            op_ff <= dps_pkg::DPS_CMD_INIT;
            idx_ff <= '0;
            wbit_ff <= 1'b1;
            init_ff <= 1'b1;
            init_done_ff <= 1'b0;
        end else if (state_ff == dps_pkg::DPS_IDLE) begin
            if (init_ff) begin
                op_ff <= dps_pkg::DPS_CMD_INIT;
                wbit_ff <= 1'b1;
            end else if (cmd_valid) begin
                op_ff <= cmd_op;
                // a sweep always starts from token zero so all eight get freed
                idx_ff <= (cmd_op == dps_pkg::DPS_CMD_INIT) ? '0 : cmd_index;
                // zero claims, one releases or withdraws a failed claim
                wbit_ff <= (cmd_op != dps_pkg::DPS_CMD_CLAIM);
                init_ff <= (cmd_op == dps_pkg::DPS_CMD_INIT);
            end
        end else if (state_ff == dps_pkg::DPS_DONE && op_ff == dps_pkg::DPS_CMD_INIT) begin
            idx_ff <= idx_ff + 1'b1;
            if (idx_ff == 3'h7) begin
                init_ff <= 1'b0;
                init_done_ff <= 1'b1;
            end
        end
    end

    // read-back sampled at strobe end; bit zero is the flag
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rsp_valid_ff <= 1'b0;
            rsp_granted_ff <= 1'b0;
            rsp_data_ff <= '0;
        end else begin
            rsp_valid_ff <= (state_ff == dps_pkg::DPS_DONE) && !init_ff;
            if (state_ff == dps_pkg::DPS_RSTB && phase_end) begin
                rsp_data_ff <= port_data_in;
                rsp_granted_ff <= !port_data_in[0]; // one means lost
            end else if (state_ff == dps_pkg::DPS_WSTB && phase_end) begin
                rsp_granted_ff <= 1'b0;
            end
        end
    end

    // pin drive: array deselected, token space selected during access
    always_comb begin
        chip_enable_n = 1'b1;
        second_chip_enable = 1'b0;
        token_space_select_n = (state_ff == dps_pkg::DPS_IDLE)
                               || (state_ff == dps_pkg::DPS_DONE);
        write_n = (state_ff != dps_pkg::DPS_WSTB);
        output_enable_n = (state_ff != dps_pkg::DPS_RSTB);
        byte_lane_enables_n = token_space_select_n ? 2'h3 : 2'h0;
        port_data_oe_n = !((state_ff == dps_pkg::DPS_WSET)
                           || (state_ff == dps_pkg::DPS_WSTB));
    end

    // address and data from flip-flops; high bits zero
    assign port_addr = {{(dps_pkg::ADDR_W-dps_pkg::INDEX_W){1'b0}}, idx_ff};
    assign port_data_out = {{(dps_pkg::DATA_W-1){1'b0}}, wbit_ff};
    assign cmd_ready = (state_ff == dps_pkg::DPS_IDLE) && !init_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_granted = rsp_granted_ff;
    assign rsp_data = rsp_data_ff;
    assign init_done = init_done_ff;

    // a claim's write strobe is always followed by a read strobe
    sequence s_claim_write;
        !write_n && port_data_out[0] == 1'b0;
    endsequence
    property p_write_then_read;
        @(posedge sys_clk) disable iff (!rstn)
        s_claim_write ##1 write_n |-> ##[1:8] !output_enable_n;
    endproperty
    a_claim_reads_back: assert property (p_write_then_read)
        else $error("claim not followed by read-back");

    a_array_deselect: assert property (@(posedge sys_clk) disable iff (!rstn)
        !token_space_select_n |-> chip_enable_n && !second_chip_enable)
        else $error("array selected during token access");

    a_no_overlap: assert property (@(posedge sys_clk) disable iff (!rstn)
        !(!write_n && !output_enable_n))
        else $error("read and write strobes overlap");

    a_high_addr_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        port_addr[dps_pkg::ADDR_W-1:dps_pkg::INDEX_W] == '0)
        else $error("upper address bits driven");

    a_write_drives_bus: assert property (@(posedge sys_clk) disable iff (!rstn)
        !write_n |-> !port_data_oe_n && port_data_out[dps_pkg::DATA_W-1:1] == '0)
        else $error("write bus not driven cleanly");

    a_init_sweep: assert property (@(posedge sys_clk) disable iff (!rstn)
        !init_done && !write_n |-> port_data_out[0])
        else $error("init wrote zero");

    a_grant_from_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
        rsp_valid && op_ff == dps_pkg::DPS_CMD_CLAIM |-> rsp_granted == !rsp_data[0])
        else $error("grant does not match read flag");

    a_release_writes_one: assert property (@(posedge sys_clk) disable iff (!rstn)
        !write_n && op_ff == dps_pkg::DPS_CMD_RELEASE |-> port_data_out[0])
        else $error("release wrote zero");
endmodule : dps_host

// ### dps_sem_model.sv
`timescale 1ns/1ps
// far device: eight token latches, left port on host pins, right port by bench
module dps_sem_model (
    input wire logic sys_clk,
    input wire logic l_sel_n,
    input wire logic l_we_n,
    input wire logic l_oe_n,
    input wire logic [2:0] l_idx,
    input wire logic l_d0,
    output logic [17:0] l_q,
    input wire logic r_wr,
    input wire logic [2:0] r_idx,
    input wire logic r_d0,
    output logic r_flag
);
    // power-up is arbitrary: high tokens start requested by the left side
    logic [7:0] req_l_ff = 8'h0f;
    logic [7:0] req_r_ff = 8'hff;
    logic [7:0] own_l_ff = 8'h00;
    logic [7:0] own_r_ff = 8'h00;
    logic we_q_ff = 1'b1; // strobe history for edge detect
    logic rd_q_ff = 1'b0;
    logic [17:0] lat_ff = 18'h00000; // value frozen for the read
    logic [17:0] idle_ff = 18'h15555; // released bus toggles, never holds
    logic rd;
    assign rd = !l_sel_n && !l_oe_n;
    // write strobe edge lands one bit in a request latch
    always_ff @(posedge sys_clk) begin
        we_q_ff <= l_we_n || l_sel_n;
        if (we_q_ff && !l_we_n && !l_sel_n) begin
            req_l_ff[l_idx] <= l_d0;
        end
        if (r_wr) begin
            req_r_ff[r_idx] <= r_d0;
        end
    end
    // ownership follows the latches; left wins a same-cycle tie
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!own_l_ff[i] && !own_r_ff[i]) begin
                own_l_ff[i] <= !req_l_ff[i];
                own_r_ff[i] <= req_l_ff[i] && !req_r_ff[i];
            end else if (own_l_ff[i] && req_l_ff[i]) begin
                own_l_ff[i] <= 1'b0;
                own_r_ff[i] <= !req_r_ff[i];
            end else if (own_r_ff[i] && req_r_ff[i]) begin
                own_r_ff[i] <= 1'b0;
                own_l_ff[i] <= !req_l_ff[i];
            end
        end
    end
    // freeze at read start so a right write cannot change it mid-read
    always_ff @(posedge sys_clk) begin
        rd_q_ff <= rd;
        idle_ff <= ~idle_ff;
        if (rd && !rd_q_ff) begin
            lat_ff <= {18{!own_l_ff[l_idx]}};
        end
    end
    assign l_q = !rd ? idle_ff : (rd_q_ff ? lat_ff : {18{!own_l_ff[l_idx]}});
    assign r_flag = !own_r_ff[r_idx];
endmodule : dps_sem_model

// ### dps_host_bench.sv
`timescale 1ns/1ps
// drives host commands and the device's right port, judges both views
module dps_host_bench;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [2:0] cmd_index = 3'h0;
    logic r_wr = 1'b0;
    logic [2:0] r_idx = 3'h0;
    logic r_d0 = 1'b1;
    logic cmd_ready, rsp_valid, rsp_granted, init_done, ce_n, ce2, sel_n, we_n, oe_n, r_flag;
    logic [1:0] be_n;
    logic [18:0] addr;
    logic [17:0] rsp_data, d_out, d_in;
    logic d_oe_n;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    dps_host dut (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_index(cmd_index), .rsp_valid(rsp_valid), .rsp_granted(rsp_granted),
        .rsp_data(rsp_data), .init_done(init_done), .chip_enable_n(ce_n),
        .second_chip_enable(ce2), .token_space_select_n(sel_n), .write_n(we_n),
        .output_enable_n(oe_n), .byte_lane_enables_n(be_n), .port_addr(addr),
        .port_data_out(d_out), .port_data_oe_n(d_oe_n), .port_data_in(d_in));
    // select only counts with array off, second enable low and lanes on
    dps_sem_model dev (.sys_clk(sys_clk), .l_sel_n(sel_n || (|be_n) || !ce_n || ce2),
        .l_we_n(we_n), .l_oe_n(oe_n), .l_idx(addr[2:0]),
        // undriven bus shows the inverse, so a write without drive lands wrong
        .l_d0(d_oe_n ? !d_out[0] : d_out[0]), .l_q(d_in),
        .r_wr(r_wr), .r_idx(r_idx), .r_d0(r_d0), .r_flag(r_flag));
    initial forever #10 sys_clk = ~sys_clk;
    // hang guard, well above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t bit %b want %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_bus(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t bus %h want %h", $time, got, exp);
        end
    endtask : chk_bus
    // one host command; waits for the response, or for ready after a sweep
    task automatic cmd(input logic [1:0] op, input logic [2:0] idx);
        int n;
        n = 0;
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_index <= idx;
        @(posedge sys_clk);
        while (cmd_ready !== 1'b1 && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        cmd_valid <= 1'b0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((op == 2'h3 ? cmd_ready !== 1'b1 : rsp_valid !== 1'b1) && n < 300);
        chk_bit(n < 300, 1'b1);
    endtask : cmd
    // right port write, then time for the latches to settle
    task automatic rwr(input logic [2:0] idx, input logic d);
        r_wr <= 1'b1;
        r_idx <= idx;
        r_d0 <= d;
        @(posedge sys_clk);
        r_wr <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : rwr
    // after the host sweep every token is free for the right side
    task automatic t_sweep();
        while (init_done !== 1'b1 && cycles < 3000) @(posedge sys_clk);
        chk_bit(init_done, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rwr(i[2:0], 1'b0);
            chk_bit(r_flag, 1'b0);
            rwr(i[2:0], 1'b1);
        end
        $display("test sweep done");
    endtask : t_sweep
    // claim, contention, hand-over and retry on one token
    task automatic t_claim();
        cmd(2'h0, 3'h2);
        chk_bit(rsp_granted, 1'b1);
        chk_bus(rsp_data, 18'h00000);
        rwr(3'h2, 1'b0);
        chk_bit(r_flag, 1'b1);
        cmd(2'h1, 3'h2);
        chk_bit(rsp_granted, 1'b0);
        repeat (2) @(posedge sys_clk);
        chk_bit(r_flag, 1'b0);
        cmd(2'h0, 3'h2);
        chk_bit(rsp_granted, 1'b0);
        chk_bus(rsp_data, 18'h3ffff);
        rwr(3'h2, 1'b1);
        cmd(2'h2, 3'h2);
        chk_bit(rsp_granted, 1'b1);
        cmd(2'h1, 3'h2);
        $display("test claim done");
    endtask : t_claim
    // re-init sweep frees a token the host held
    task automatic t_init();
        cmd(2'h0, 3'h6);
        chk_bit(rsp_granted, 1'b1);
        cmd(2'h3, 3'h0);
        rwr(3'h6, 1'b0);
        chk_bit(r_flag, 1'b0);
        rwr(3'h6, 1'b1);
        $display("test init done");
    endtask : t_init
    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        t_sweep();
        t_claim();
        t_init();
        results();
    end
endmodule : dps_host_bench
